// >>> common/alu_subset_pkg.sv
// package for the instruction subset datapath: opcodes, widths, selectors, reset values
// assumes one instruction issued per clock, file register data supplied by
// the surrounding core in the same cycle as the instruction
package alu_subset_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W = 4;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ROTATE_RIGHT_CARRY = 4'h1,
        OP_SUBTRACT_ACC_FROM_FILE = 4'h2,
        OP_SUBTRACT_WITH_BORROW = 4'h3,
        OP_NIBBLE_EXCHANGE = 4'h4,
        OP_XOR_LITERAL = 4'h5,
        OP_XOR_FILE = 4'h6,
        OP_PIN_DIRECTION_LOAD = 4'h7,
        OP_SLEEP = 4'h8
    } opcode_t;

    typedef enum logic [0:0] {
        RUN_ST = 1'b0,
        SLEEP_ST = 1'b1
    } power_state_t;

    // destination select values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // direction-load port selectors
    localparam logic [2:0] DIR_SEL_A = 3'h5;
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;

    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

endpackage

// >>> rtl/alu_subset_core.sv
// combinational result and flag computation for the instruction subset
// assumes operands are stable within the cycle; no state held here
`timescale 1ns/100ps
module alu_subset_core (
    input wire alu_subset_pkg::opcode_t op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] literal_i,
    input wire logic carry_i,
    input wire logic half_carry_i,
    output logic [7:0] result_o,
    output logic carry_o,
    output logic half_carry_o,
    output logic zero_upd_o
);

    // ==========================================================
    // subtraction helper, carry set means no borrow
    function automatic logic [8:0] sub9(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic bin);
        sub9 = {1'b0, a} + {1'b0, ~b} + {8'h00, ~bin};
    endfunction

    function automatic logic [4:0] sub5(input logic [3:0] a,
                                        input logic [3:0] b,
                                        input logic bin);
        sub5 = {1'b0, a} + {1'b0, ~b} + {4'h0, ~bin};
    endfunction

    logic [8:0] diff;
    logic [4:0] ndiff;
    logic borrow_in;

    always_comb begin
        // plain subtract behaves as no incoming borrow
        borrow_in = (op_i == alu_subset_pkg::OP_SUBTRACT_WITH_BORROW)
                    ? ~carry_i : 1'b0;
        diff = sub9(file_i, acc_i, borrow_in);
        ndiff = sub5(file_i[3:0], acc_i[3:0], borrow_in);
    end

    always_comb begin
        result_o = file_i;
        carry_o = carry_i;
        half_carry_o = half_carry_i;
        zero_upd_o = 1'b0;
        case (op_i)
            alu_subset_pkg::OP_ROTATE_RIGHT_CARRY: begin
                result_o = {carry_i, file_i[7:1]}; // RQ1
                carry_o = file_i[0]; // RQ1
            end
            alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE,
            alu_subset_pkg::OP_SUBTRACT_WITH_BORROW: begin
                result_o = diff[7:0]; // RQ5 RQ6
                carry_o = diff[8]; // RQ5 RQ6
                half_carry_o = ndiff[4]; // RQ5 RQ6
                zero_upd_o = 1'b1;
            end
            alu_subset_pkg::OP_NIBBLE_EXCHANGE: begin
                result_o = {file_i[3:0], file_i[7:4]}; // RQ7
            end
            alu_subset_pkg::OP_XOR_LITERAL: begin
                result_o = acc_i ^ literal_i; // RQ8
                zero_upd_o = 1'b1;
            end
            alu_subset_pkg::OP_XOR_FILE: begin
                result_o = acc_i ^ file_i; // RQ9
                zero_upd_o = 1'b1;
            end
            default: begin
                result_o = acc_i;
            end
        endcase
    end

endmodule // alu_subset_core

// >>> rtl/sleep_control.sv
// sleep entry: watchdog clear, status flag update, low-power state
// assumes wake_i comes from the surrounding core's wake logic
`timescale 1ns/100ps
module sleep_control (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sleep_i,
    input wire logic wake_i,
    input wire logic wdt_tick_i,
    output logic [7:0] wdt_count_o,
    output logic [7:0] prescale_o,
    output logic expiry_n_o,
    output logic power_down_n_o,
    output logic asleep_o
);

    alu_subset_pkg::power_state_t state_q;

    // ==========================================================
    // watchdog counter and prescaler
    always_ff @(posedge clk_i) begin
        if (!rstn_i || sleep_i) begin
            wdt_count_o <= alu_subset_pkg::WDT_CLEAR; // RQ3
            prescale_o <= alu_subset_pkg::PRESCALE_CLEAR; // RQ3
        end else if (wdt_tick_i) begin
            {wdt_count_o, prescale_o} <= {wdt_count_o, prescale_o} + 16'h0001;
        end
    end

    // ==========================================================
    // status flags, both active low in meaning
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            expiry_n_o <= 1'b1;
            power_down_n_o <= 1'b1;
        end else if (sleep_i) begin
            expiry_n_o <= 1'b1; // RQ3
            power_down_n_o <= 1'b0; // RQ3
        end
    end

    // ==========================================================
    // power state; flags settle in the same edge that halts the clock gate
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= alu_subset_pkg::RUN_ST;
        end else begin
            case (state_q)
                alu_subset_pkg::RUN_ST:
                    if (sleep_i) state_q <= alu_subset_pkg::SLEEP_ST; // RQ4
                alu_subset_pkg::SLEEP_ST:
                    if (wake_i) state_q <= alu_subset_pkg::RUN_ST;
                default: state_q <= alu_subset_pkg::RUN_ST;
            endcase
        end
    end

    assign asleep_o = (state_q == alu_subset_pkg::SLEEP_ST);

    a_sleep_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sleep_i |=> !power_down_n_o && expiry_n_o && wdt_count_o == 8'h00)
        else $error("sleep did not set flags"); // RQ3

    a_sleep_state: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sleep_i && !asleep_o |=> asleep_o)
        else $error("sleep state not entered"); // RQ4

endmodule // sleep_control

// >>> rtl/alu_subset_top.sv
// execution datapath for a small microcontroller instruction subset
// assumes the core decodes and fetches file data; writes go back via
// file_we_o with file_addr_o and file_wdata_o one cycle later
`timescale 1ns/100ps

// Function
// RQ1 - rotate right through carry, carry only
// RQ2 - seven bit address, destination bit picks target
// RQ3 - sleep clears watchdog, sets expiry, clears powerdown
// RQ4 - sleep halts instruction clock afterwards
// RQ5 - subtract acc from file, carry halfcarry zero
// RQ6 - subtract with borrow uses inverted carry
// RQ7 - nibble exchange, no flag change
// RQ8 - xor literal into acc, zero only
// RQ9 - xor file to destination, zero only
// RQ10 - direction load copies acc to port
// RQ11 - zero set when result is zero
// RQ12 - each instruction takes one cycle
module alu_subset_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic issue_i,
    input wire alu_subset_pkg::opcode_t op_i,
    input wire logic [6:0] file_addr_i,
    input wire logic dest_i,
    input wire logic [7:0] literal_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic wake_i,
    input wire logic wdt_tick_i,
    output logic [7:0] acc_o,
    output logic carry_o,
    output logic half_carry_flag_o,
    output logic zero_o,
    output logic file_we_o,
    output logic [6:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    output logic [7:0] port_a_direction_o,
    output logic [7:0] port_b_direction_o,
    output logic [7:0] port_c_direction_o,
    output logic [7:0] watchdog_counter_o,
    output logic [7:0] watchdog_prescale_o,
    output logic watchdog_expiry_flag_n_o,
    output logic power_down_flag_n_o,
    output logic asleep_o,
    output logic done_o
);

    logic [7:0] result;
    logic carry_n;
    logic half_n;
    logic zero_upd;
    logic go;
    logic file_op;

    // instructions are ignored while the processor sleeps
    assign go = issue_i && !asleep_o;

    assign file_op = (op_i == alu_subset_pkg::OP_ROTATE_RIGHT_CARRY)
        || (op_i == alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE)
        || (op_i == alu_subset_pkg::OP_SUBTRACT_WITH_BORROW)
        || (op_i == alu_subset_pkg::OP_NIBBLE_EXCHANGE)
        || (op_i == alu_subset_pkg::OP_XOR_FILE);

    // ==========================================================
    // datapath
    alu_subset_core u_core (
        .op_i(op_i),
        .acc_i(acc_o),
        .file_i(file_rdata_i),
        .literal_i(literal_i),
        .carry_i(carry_o),
        .half_carry_i(half_carry_flag_o),
        .result_o(result),
        .carry_o(carry_n),
        .half_carry_o(half_n),
        .zero_upd_o(zero_upd)
    );

    // ==========================================================
    // accumulator
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_o <= alu_subset_pkg::ACC_RESET;
        end else if (go) begin
            if (op_i == alu_subset_pkg::OP_XOR_LITERAL) begin
                acc_o <= result; // RQ8
            end else if (file_op && dest_i == alu_subset_pkg::DEST_ACC) begin
                acc_o <= result; // RQ2
            end
        end
    end

    // ==========================================================
    // file register write back, issued in the cycle after the op
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            file_we_o <= 1'b0;
            file_addr_o <= 7'h00;
            file_wdata_o <= alu_subset_pkg::ZERO_BYTE;
        end else begin
            file_we_o <= go && file_op
                         && dest_i == alu_subset_pkg::DEST_FILE; // RQ2
            file_addr_o <= file_addr_i;
            file_wdata_o <= result;
        end
    end

    // ==========================================================
    // status flags
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            carry_o <= 1'b0;
            half_carry_flag_o <= 1'b0;
            zero_o <= 1'b0;
        end else if (go) begin
            carry_o <= carry_n; // RQ1
            half_carry_flag_o <= half_n; // RQ5
            if (zero_upd) begin
                zero_o <= (result == alu_subset_pkg::ZERO_BYTE); // RQ11
            end
        end
    end

    // ==========================================================
    // port direction registers, reset to all inputs
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            port_a_direction_o <= alu_subset_pkg::DIR_RESET;
            port_b_direction_o <= alu_subset_pkg::DIR_RESET;
            port_c_direction_o <= alu_subset_pkg::DIR_RESET;
        end else if (go && op_i == alu_subset_pkg::OP_PIN_DIRECTION_LOAD) begin
            // selector outside 5..7 loads nothing
            case (file_addr_i[2:0])
                alu_subset_pkg::DIR_SEL_A: port_a_direction_o <= acc_o; // RQ10
                alu_subset_pkg::DIR_SEL_B: port_b_direction_o <= acc_o; // RQ10
                alu_subset_pkg::DIR_SEL_C: port_c_direction_o <= acc_o; // RQ10
                default: ;
            endcase
        end
    end

    // ==========================================================
    // one-cycle completion strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= go; // RQ12
        end
    end

    // ==========================================================
    // sleep handling
    sleep_control u_sleep (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .sleep_i(go && op_i == alu_subset_pkg::OP_SLEEP),
        .wake_i(wake_i),
        .wdt_tick_i(wdt_tick_i),
        .wdt_count_o(watchdog_counter_o),
        .prescale_o(watchdog_prescale_o),
        .expiry_n_o(watchdog_expiry_flag_n_o),
        .power_down_n_o(power_down_flag_n_o),
        .asleep_o(asleep_o)
    );

    // ==========================================================
    // checks
    a_rotate_result: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_ROTATE_RIGHT_CARRY && dest_i
        |=> file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])}
            && carry_o == $past(file_rdata_i[0]))
        else $error("rotate right wrong"); // RQ1

    a_dest_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && file_op && !dest_i |=> !file_we_o && acc_o == file_wdata_o)
        else $error("destination select wrong"); // RQ2

    a_sub_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE
        |=> carry_o == ($past(acc_o) <= $past(file_rdata_i))
            && file_wdata_o == $past(file_rdata_i) - $past(acc_o))
        else $error("subtract wrong"); // RQ5

    a_sub_borrow: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_SUBTRACT_WITH_BORROW
        |=> file_wdata_o == $past(file_rdata_i) - $past(acc_o)
            - {7'h00, !$past(carry_o)})
        else $error("subtract with borrow wrong"); // RQ6

    a_swap_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_NIBBLE_EXCHANGE
        |=> $stable(carry_o) && $stable(zero_o)
            && file_wdata_o == {$past(file_rdata_i[3:0]),
                                $past(file_rdata_i[7:4])})
        else $error("nibble exchange wrong"); // RQ7

    a_xor_literal: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_XOR_LITERAL
        |=> acc_o == ($past(acc_o) ^ $past(literal_i))
            && zero_o == (acc_o == 8'h00) && $stable(carry_o))
        else $error("xor literal wrong"); // RQ8 RQ11

    a_xor_file: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_XOR_FILE
        |=> file_wdata_o == ($past(acc_o) ^ $past(file_rdata_i))
            && $stable(half_carry_flag_o))
        else $error("xor file wrong"); // RQ9

    a_dir_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_PIN_DIRECTION_LOAD
        && file_addr_i[2:0] == 3'h6
        |=> port_b_direction_o == $past(acc_o) && $stable(zero_o))
        else $error("direction load wrong"); // RQ10

    a_one_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go |=> done_o)
        else $error("instruction not done in one cycle"); // RQ12

    a_rotate_acc: assert property ( // RQ1
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_ROTATE_RIGHT_CARRY && !dest_i
        |=> acc_o == {$past(carry_o), $past(file_rdata_i[7:1])}
            && $stable(zero_o) && $stable(half_carry_flag_o))
        else $error("rotate into accumulator wrong");

    a_sub_half: assert property ( // RQ5 RQ11
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE
        |=> half_carry_flag_o
                == ($past(acc_o[3:0]) <= $past(file_rdata_i[3:0]))
            && zero_o == (file_wdata_o == 8'h00))
        else $error("subtract half carry or zero wrong");

    a_borrow_flags: assert property ( // RQ6 RQ11
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_SUBTRACT_WITH_BORROW
        |=> carry_o == ({1'b0, $past(acc_o)} + {8'h00, !$past(carry_o)}
                        <= {1'b0, $past(file_rdata_i)})
            && half_carry_flag_o == ({1'b0, $past(acc_o[3:0])}
                + {4'h0, !$past(carry_o)}
                <= {1'b0, $past(file_rdata_i[3:0])})
            && zero_o == (file_wdata_o == 8'h00))
        else $error("subtract with borrow flags wrong");

    a_swap_acc: assert property ( // RQ7
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_NIBBLE_EXCHANGE && !dest_i
        |=> acc_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])}
            && $stable(half_carry_flag_o))
        else $error("nibble exchange into accumulator wrong");

    a_xor_file_zero: assert property ( // RQ9 RQ11
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_XOR_FILE
        |=> zero_o == (file_wdata_o == 8'h00) && $stable(carry_o))
        else $error("xor file zero wrong");

    a_file_write: assert property ( // RQ2
        @(posedge clk_i) disable iff (!rstn_i)
        go && file_op && dest_i
        |=> file_we_o && file_addr_o == $past(file_addr_i)
            && $stable(acc_o))
        else $error("file write back wrong");

    a_file_quiet: assert property ( // RQ2
        @(posedge clk_i) disable iff (!rstn_i)
        !go || !file_op |=> !file_we_o)
        else $error("file written without a file op");

    a_dir_port_a: assert property ( // RQ10
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_PIN_DIRECTION_LOAD
        && file_addr_i[2:0] == 3'h5
        |=> port_a_direction_o == $past(acc_o)
            && $stable(port_b_direction_o) && $stable(port_c_direction_o))
        else $error("port a direction load wrong");

    a_dir_other: assert property ( // RQ10
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_PIN_DIRECTION_LOAD
        && file_addr_i[2:0] < 3'h5
        |=> $stable(port_a_direction_o) && $stable(port_b_direction_o)
            && $stable(port_c_direction_o))
        else $error("direction loaded outside 5 to 7");

    a_dir_flags: assert property ( // RQ10
        @(posedge clk_i) disable iff (!rstn_i)
        go && op_i == alu_subset_pkg::OP_PIN_DIRECTION_LOAD
        |=> $stable(carry_o) && $stable(half_carry_flag_o)
            && $stable(zero_o) && $stable(acc_o))
        else $error("direction load touched flags");

    a_asleep_idle: assert property ( // RQ4
        @(posedge clk_i) disable iff (!rstn_i)
        asleep_o && !wake_i |=> asleep_o && !done_o && $stable(acc_o))
        else $error("instruction ran while asleep");

    a_flags_sleep_only: assert property ( // RQ3
        @(posedge clk_i) disable iff (!rstn_i)
        !(go && op_i == alu_subset_pkg::OP_SLEEP)
        |=> $stable(watchdog_expiry_flag_n_o)
            && $stable(power_down_flag_n_o))
        else $error("status flags moved without sleep");

endmodule // alu_subset_top

// >>> sim/mcu_alu_instruction_subset_tb_top.sv
// testbench for the instruction subset datapath, one task per scenario
// assumes the design holds its own assertions; bench drives every port
`timescale 1ns/100ps
module mcu_alu_instruction_subset_tb_top;
    // ==========================================================
    // signals
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic issue_i = 1'b0;
    alu_subset_pkg::opcode_t op_i = alu_subset_pkg::OP_NONE;
    logic [6:0] file_addr_i = 7'h00;
    logic dest_i = 1'b0;
    logic [7:0] literal_i = 8'h00;
    logic [7:0] file_rdata_i = 8'h00;
    logic wake_i = 1'b0;
    logic wdt_tick_i = 1'b0;
    logic [7:0] acc_o, file_wdata_o, watchdog_counter_o, watchdog_prescale_o;
    logic [7:0] port_a_direction_o, port_b_direction_o, port_c_direction_o;
    logic [6:0] file_addr_o;
    logic carry_o, half_carry_flag_o, zero_o, file_we_o, done_o, asleep_o;
    logic watchdog_expiry_flag_n_o, power_down_flag_n_o;
    int n_errors = 0;
    int checks = 0;
    // bench's own view of the accumulator, never read back from the design
    logic [7:0] acc_m = 8'h00;
    logic [7:0] dir_m [3] = '{8'hFF, 8'hFF, 8'hFF};

    always #5 clk_i = ~clk_i;

    alu_subset_top u_alu_subset_top (
        .clk_i(clk_i), .rstn_i(rstn_i), .issue_i(issue_i), .op_i(op_i),
        .file_addr_i(file_addr_i), .dest_i(dest_i), .literal_i(literal_i),
        .file_rdata_i(file_rdata_i), .wake_i(wake_i),
        .wdt_tick_i(wdt_tick_i), .acc_o(acc_o), .carry_o(carry_o),
        .half_carry_flag_o(half_carry_flag_o), .zero_o(zero_o),
        .file_we_o(file_we_o), .file_addr_o(file_addr_o),
        .file_wdata_o(file_wdata_o),
        .port_a_direction_o(port_a_direction_o),
        .port_b_direction_o(port_b_direction_o),
        .port_c_direction_o(port_c_direction_o),
        .watchdog_counter_o(watchdog_counter_o),
        .watchdog_prescale_o(watchdog_prescale_o),
        .watchdog_expiry_flag_n_o(watchdog_expiry_flag_n_o),
        .power_down_flag_n_o(power_down_flag_n_o), .asleep_o(asleep_o),
        .done_o(done_o)
    );

    // ==========================================================
    // shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // order is carry, half carry, zero
    task automatic flags(input logic [2:0] exp);
        chk({5'h00, carry_o, half_carry_flag_o, zero_o}, {5'h00, exp});
    endtask

    // one issue cycle; looks at the outputs just after the taking edge
    task automatic exec(input alu_subset_pkg::opcode_t op,
                        input logic [6:0] a, input logic d,
                        input logic [7:0] l, input logic [7:0] f,
                        input logic taken);
        @(posedge clk_i);
        issue_i <= 1'b1;
        op_i <= op;
        file_addr_i <= a;
        dest_i <= d;
        literal_i <= l;
        file_rdata_i <= f;
        @(posedge clk_i);
        issue_i <= 1'b0;
        #1;
        chk({7'h00, done_o}, {7'h00, taken});
        chk({7'h00, file_we_o}, {7'h00, taken & d});
        if (taken & d) chk({1'b0, file_addr_o}, {1'b0, a});
    endtask

    task automatic set_acc(input logic [7:0] v);
        exec(alu_subset_pkg::OP_XOR_LITERAL, 7'h00, 1'b0, acc_m ^ v, 8'h00,
             1'b1);
        chk(acc_o, v);
        acc_m = v;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk(acc_o, 8'h00);
        flags(3'b000);
        chk(port_a_direction_o, 8'hFF);
        chk(port_c_direction_o, 8'hFF);
        chk({6'h00, watchdog_expiry_flag_n_o, power_down_flag_n_o}, 8'h03);
        chk({6'h00, asleep_o, done_o}, 8'h00);
        $display("test reset done");
    endtask

    // two issues back to back, the second sees the first's result
    task automatic t_xor_lit;
        @(posedge clk_i);
        issue_i <= 1'b1;
        op_i <= alu_subset_pkg::OP_XOR_LITERAL;
        literal_i <= 8'h5A;
        @(posedge clk_i);
        #1;
        chk(acc_o, 8'h5A);
        flags(3'b000);
        @(posedge clk_i);
        issue_i <= 1'b0;
        #1;
        chk(acc_o, 8'h00);
        flags(3'b001);
        chk({7'h00, done_o}, 8'h01);
        $display("test xor literal done");
    endtask

    task automatic t_sub;
        set_acc(8'h03);
        exec(alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h7F, 1'b1, 8'h00,
             8'h05, 1'b1);
        chk(file_wdata_o, 8'h02);
        flags(3'b110);
        chk(acc_o, 8'h03);
        exec(alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h00, 1'b0, 8'h00,
             8'h03, 1'b1);
        chk(acc_o, 8'h00);
        flags(3'b111);
        acc_m = 8'h00;
        set_acc(8'h10);
        exec(alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h01, 1'b0, 8'h00,
             8'h0F, 1'b1);
        chk(acc_o, 8'hFF);
        flags(3'b010);
        acc_m = 8'hFF;
        $display("test subtract done");
    endtask

    // carry is clear on entry, so the first one borrows
    task automatic t_subb;
        exec(alu_subset_pkg::OP_SUBTRACT_WITH_BORROW, 7'h22, 1'b1, 8'h00,
             8'h05, 1'b1);
        chk(file_wdata_o, 8'h05);
        flags(3'b000);
        exec(alu_subset_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h22, 1'b1, 8'h00,
             8'hFF, 1'b1);
        flags(3'b111);
        exec(alu_subset_pkg::OP_SUBTRACT_WITH_BORROW, 7'h22, 1'b0, 8'h00,
             8'hFF, 1'b1);
        chk(acc_o, 8'h00);
        flags(3'b111);
        acc_m = 8'h00;
        $display("test subtract borrow done");
    endtask

    task automatic t_rotate;
        exec(alu_subset_pkg::OP_ROTATE_RIGHT_CARRY, 7'h40, 1'b1, 8'h00,
             8'h81, 1'b1);
        chk(file_wdata_o, 8'hC0);
        flags(3'b111);
        exec(alu_subset_pkg::OP_ROTATE_RIGHT_CARRY, 7'h40, 1'b0, 8'h00,
             8'h02, 1'b1);
        chk(acc_o, 8'h81);
        flags(3'b011);
        acc_m = 8'h81;
        $display("test rotate done");
    endtask

    task automatic t_swap;
        exec(alu_subset_pkg::OP_NIBBLE_EXCHANGE, 7'h11, 1'b0, 8'h00, 8'hA5,
             1'b1);
        chk(acc_o, 8'h5A);
        exec(alu_subset_pkg::OP_NIBBLE_EXCHANGE, 7'h12, 1'b1, 8'h00, 8'h3C,
             1'b1);
        chk(file_wdata_o, 8'hC3);
        chk(acc_o, 8'h5A);
        flags(3'b011);
        acc_m = 8'h5A;
        $display("test swap done");
    endtask

    task automatic t_xor_file;
        exec(alu_subset_pkg::OP_XOR_FILE, 7'h7F, 1'b1, 8'h00, 8'h5A, 1'b1);
        chk(file_wdata_o, 8'h00);
        chk(acc_o, 8'h5A);
        flags(3'b011);
        exec(alu_subset_pkg::OP_XOR_FILE, 7'h00, 1'b0, 8'h00, 8'h0F, 1'b1);
        chk(acc_o, 8'h55);
        flags(3'b010);
        acc_m = 8'h55;
        $display("test xor file done");
    endtask

    // selector 4 lies outside the port range and must load nothing
    task automatic t_dir;
        for (int s = 4; s <= 7; s++) begin
            set_acc(8'(8'h30 + s));
            exec(alu_subset_pkg::OP_PIN_DIRECTION_LOAD, 7'(s), 1'b0, 8'h00,
                 8'h00, 1'b1);
            if (s > 4) dir_m[s - 5] = acc_m;
            chk(port_a_direction_o, dir_m[0]);
            chk(port_b_direction_o, dir_m[1]);
            chk(port_c_direction_o, dir_m[2]);
            flags(3'b010);
        end
        $display("test direction done");
    endtask

    task automatic t_sleep;
        @(posedge clk_i);
        wdt_tick_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        wdt_tick_i <= 1'b0;
        #1;
        chk(watchdog_counter_o, 8'h01);
        chk(watchdog_prescale_o, 8'h2C);
        exec(alu_subset_pkg::OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
        chk(watchdog_counter_o, 8'h00);
        chk(watchdog_prescale_o, 8'h00);
        chk({6'h00, watchdog_expiry_flag_n_o, power_down_flag_n_o},
            8'h02);
        chk({7'h00, asleep_o}, 8'h01);
        // a halted core must not execute anything it is handed
        exec(alu_subset_pkg::OP_XOR_LITERAL, 7'h00, 1'b0, 8'hFF, 8'h00,
             1'b0);
        chk(acc_o, acc_m);
        @(posedge clk_i);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        #1;
        chk({7'h00, asleep_o}, 8'h00);
        set_acc(8'h00);
        $display("test sleep done");
    endtask

    // ==========================================================
    // run control
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // the sequence needs well under 1000 cycles
    initial begin
        #200000;
        n_errors++;
        stop_test;
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        t_reset;
        t_xor_lit;
        t_sub;
        t_subb;
        t_rotate;
        t_swap;
        t_xor_file;
        t_dir;
        t_sleep;
        stop_test;
    end
endmodule // mcu_alu_instruction_subset_tb_top
